/* converter_serial_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes an apb slave with 32-bit words, one register per aligned word
`ifndef CONVERTER_SERIAL_DEFINES_SVH
`define CONVERTER_SERIAL_DEFINES_SVH
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_STATUS 8'h08
`define OFS_TX_SLOT 8'h0c
`define OFS_RX_SLOT 8'h10
`define OFS_ERR_IRQ_EN 8'h14
`define OFS_TX_HOLD_0 8'h20
`define OFS_RX_HOLD_0 8'h30
`define CTRL_RESET 16'h0000
`define SLOT_EN_RESET 16'h0000
`define HOLD_RESET 16'h0000
`define C1_ENABLE 15
`define C1_LOOPBACK 11
`define C1_MASTER 8
`define C1_UNF_MODE 7
`define C1_ALIGN 5
`define C2_BUFFER_LENGTH_HI 11
`define C2_BUFFER_LENGTH_LO 10
`define C2_FWC_HI 7
`define C2_FWC_LO 4
`define C2_WS_HI 3
`define C2_WS_LO 0
`define ST_TEMPTY 0
`define ST_TX_UNDERFLOW_FLAG 1
`define ST_RFULL 2
`define ST_ROV 3
`define ST_SLOT_LO 7
`define STARTUP_BCLKS 2'h3
`endif

/* converter_serial_pkg.sv */
// types shared by the slot buffer block
// assumes the defines header is compiled alongside
`default_nettype none
package converter_serial_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_STARTUP = 2'b01,
    ST_RUN = 2'b10
  } port_state_t;

  typedef struct packed {
    logic enable;
    logic loopback_ctl;
    logic master;
    logic underflow_fill_mode;
    logic sync_align_ctl;
    logic [1:0] buffer_length;
    logic [3:0] frame_word_count;
    logic [3:0] word_size;
  } port_cfg_t;

  typedef struct packed {
    logic [4:0] slot;
    logic rx_overflow_flag;
    logic rx_full_flag;
    logic tx_underflow_flag;
    logic tx_empty_flag;
  } port_status_t;
endpackage : converter_serial_pkg
`default_nettype wire

/* converter_serial_slot_buffer.sv */
// framed serial port slot buffer with apb registers
// assumes bit clock and frame sync pins are asynchronous to pclk
// What this block does
// - pointer advances when tx or rx enable set for the slot
// - tx and rx share the same buffer index per slot
// - pointer returns to zero after length plus one words or location three
// - pointer steps when all bits of an enabled slot are shifted
// - dma use sets length zero; only location zero used
// - length zero gives a dma request after every word of a tx or rx enabled slot
// - msb first; short words sit in upper bits
// - rx-only slot sends zeros but captures input
// - unused locations never touch status flags
// - rx full sets on new words, clears after all in-use reads
// - rx overflow sets on refill before read, clears on read
// - tx empty sets on copy, clears on in-use write
// - tx underflow sets on copy of unwritten register, clears on write
// - current slot index in status bits 11 to 7
// - loopback routes serial out to serial in
// - underflow sends zeros or the last written word
// - align bit picks start one bit clock after or with frame sync
// - buffer interrupt per buffer length and three bit clocks after enable
// - separately enabled error interrupt on underflow or overflow
// - master drives frame sync again after the frame's words
// - buffer length field gives one to four words
// - word size field gives bits per slot as value plus one
// - irq flag is rx full or tx empty
//
// Local design decisions: the register addresses and the APB slave port.
`default_nettype none
`include "converter_serial_defines.svh"
module converter_serial_slot_buffer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic bit_clock_pin,
  input wire logic serial_in_pin,
  input wire logic frame_sync_pin_i,
  output logic frame_sync_pin_o,
  output logic frame_sync_pin_oe,
  output logic serial_out_pin,
  output logic port_irq_flag,
  output logic buf_irq,
  output logic err_irq,
  output logic dma_req
);
  logic [15:0] ctl1_r, ctl2_r, tx_slot_enable_reg, rx_slot_enable_reg;
  logic err_en_r;
  logic [15:0] tx_hold_r [4];
  logic [15:0] rx_hold_r [4];
  logic [15:0] tx_buf_r [4];
  logic [15:0] rx_buf_r [4];
  logic [3:0] written_r, unread_r, ovf_r, unf_r;
  logic rfull_r, tempty_r;
  logic [2:0] bclk_s, sdi_s, fs_s;
  converter_serial_pkg::port_state_t state_r;
  converter_serial_pkg::port_cfg_t cfg;
  converter_serial_pkg::port_status_t stat;
  logic [1:0] ptr_r, start_cnt_r;
  logic [3:0] slot_r, bit_r;
  logic active_r, pend_r;
  logic running, starting;
  logic [15:0] txsh_r, rxsh_r;
  logic bclk_rise, fs_seen, start, step, word_end, slot_used, adv;
  logic startup_done, xfer, sout_nxt, sin, tx_on, rx_on;
  logic [3:0] slot_cur, bit_cur, inuse, tx_wr, rx_rd;
  logic [15:0] tx_word, rx_word, rxsh_nxt;
  logic wr, rd;

  function automatic logic [3:0] hold_sel(input logic [7:0] a,
                                          input logic [7:0] base);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 0; i < 4; i++) begin
      if (a == base + 8'(4 * i)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : hold_sel

  assign cfg.enable = ctl1_r[`C1_ENABLE];
  assign cfg.loopback_ctl = ctl1_r[`C1_LOOPBACK];
  assign cfg.master = ctl1_r[`C1_MASTER];
  assign cfg.underflow_fill_mode = ctl1_r[`C1_UNF_MODE];
  assign cfg.sync_align_ctl = ctl1_r[`C1_ALIGN];
  assign cfg.buffer_length = ctl2_r[`C2_BUFFER_LENGTH_HI:`C2_BUFFER_LENGTH_LO];
  assign cfg.frame_word_count = ctl2_r[`C2_FWC_HI:`C2_FWC_LO];
  assign cfg.word_size = ctl2_r[`C2_WS_HI:`C2_WS_LO];

  // in-use locations for the buffer length
  always_comb begin
    unique case (cfg.buffer_length)
      2'h0: inuse = 4'h1;
      2'h1: inuse = 4'h3;
      2'h2: inuse = 4'h7;
      2'h3: inuse = 4'hf;
    endcase
  end

  assign wr = psel & penable & pready & pwrite;
  assign rd = psel & penable & pready & ~pwrite;
  assign tx_wr = wr ? hold_sel(paddr, `OFS_TX_HOLD_0) & inuse : 4'h0;
  assign rx_rd = rd ? hold_sel(paddr, `OFS_RX_HOLD_0) & inuse : 4'h0;

  // the link moves only while the enable bit is set
  assign running = cfg.enable
    & (state_r == converter_serial_pkg::ST_RUN);
  assign starting = cfg.enable
    & (state_r == converter_serial_pkg::ST_STARTUP);

  // serial link timing
  assign bclk_rise = bclk_s[1] & ~bclk_s[2];
  assign fs_seen = cfg.master ? frame_sync_pin_o : fs_s[1];
  assign start = bclk_rise & running
    & ((fs_seen & cfg.sync_align_ctl) | pend_r);
  assign step = bclk_rise & running
    & (active_r | start);
  assign slot_cur = start ? 4'h0 : slot_r;
  assign bit_cur = start ? 4'h0 : bit_r;
  assign tx_on = tx_slot_enable_reg[slot_cur];
  assign rx_on = rx_slot_enable_reg[slot_cur];
  assign slot_used = tx_on | rx_on;
  assign word_end = step & (bit_cur == cfg.word_size);
  assign adv = word_end & slot_used;
  assign startup_done = bclk_rise
    & starting
    & (start_cnt_r == `STARTUP_BCLKS - 2'h1);
  assign xfer = (adv & (ptr_r == cfg.buffer_length)) | startup_done;

  assign tx_word = tx_on ? tx_buf_r[ptr_r] : 16'h0000;
  assign sout_nxt = (bit_cur == 4'h0) ? tx_word[15] : txsh_r[15];
  assign sin = cfg.loopback_ctl ? sout_nxt : sdi_s[1];
  assign rxsh_nxt = {rxsh_r[14:0], sin};
  assign rx_word = rxsh_nxt << (4'hf - cfg.word_size);

  // pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_s <= 3'h0;
      sdi_s <= 3'h0;
      fs_s <= 3'h0;
    end else begin
      bclk_s <= {bclk_s[1:0], bit_clock_pin};
      sdi_s <= {sdi_s[1:0], serial_in_pin};
      fs_s <= {fs_s[1:0], frame_sync_pin_i};
    end
  end

  // apb slave: one wait-free access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (psel & ~penable) begin
        unique case (paddr)
          `OFS_CTRL_ONE: prdata <= {16'h0, ctl1_r};
          `OFS_CTRL_TWO: prdata <= {16'h0, ctl2_r};
          `OFS_STATUS: prdata <= {20'h0, stat[8:4], 3'h0, stat[3:0]};
          `OFS_TX_SLOT: prdata <= {16'h0, tx_slot_enable_reg};
          `OFS_RX_SLOT: prdata <= {16'h0, rx_slot_enable_reg};
          `OFS_ERR_IRQ_EN: prdata <= {31'h0, err_en_r};
          `OFS_RX_HOLD_0: prdata <= {16'h0, rx_hold_r[0]};
          `OFS_RX_HOLD_0 + 8'h4: prdata <= {16'h0, rx_hold_r[1]};
          `OFS_RX_HOLD_0 + 8'h8: prdata <= {16'h0, rx_hold_r[2]};
          `OFS_RX_HOLD_0 + 8'hc: prdata <= {16'h0, rx_hold_r[3]};
          `OFS_TX_HOLD_0, `OFS_TX_HOLD_0 + 8'h4,
          `OFS_TX_HOLD_0 + 8'h8, `OFS_TX_HOLD_0 + 8'hc: prdata <= 32'h0;
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= `CTRL_RESET;
      ctl2_r <= `CTRL_RESET;
      tx_slot_enable_reg <= `SLOT_EN_RESET;
      rx_slot_enable_reg <= `SLOT_EN_RESET;
      err_en_r <= 1'b0;
    end else if (wr) begin
      if (paddr == `OFS_CTRL_ONE) ctl1_r <= pwdata[15:0];
      if (paddr == `OFS_CTRL_TWO) ctl2_r <= pwdata[15:0];
      if (paddr == `OFS_TX_SLOT) tx_slot_enable_reg <= pwdata[15:0];
      if (paddr == `OFS_RX_SLOT) rx_slot_enable_reg <= pwdata[15:0];
      if (paddr == `OFS_ERR_IRQ_EN) err_en_r <= pwdata[0];
    end
  end

  // enable sequencing, slot and bit counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= converter_serial_pkg::ST_IDLE;
      start_cnt_r <= 2'h0;
      ptr_r <= 2'h0;
      slot_r <= 4'h0;
      bit_r <= 4'h0;
      active_r <= 1'b0;
      pend_r <= 1'b0;
      frame_sync_pin_o <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
    end else if (!cfg.enable) begin
      state_r <= converter_serial_pkg::ST_IDLE;
      ptr_r <= 2'h0;
      start_cnt_r <= 2'h0;
      slot_r <= 4'h0;
      bit_r <= 4'h0;
      active_r <= 1'b0;
      pend_r <= 1'b0;
      frame_sync_pin_o <= 1'b0;
      frame_sync_pin_oe <= 1'b0;
    end else begin
      frame_sync_pin_oe <= cfg.master;
      unique case (state_r)
        converter_serial_pkg::ST_IDLE:
          state_r <= converter_serial_pkg::ST_STARTUP;
        converter_serial_pkg::ST_STARTUP: begin
          if (bclk_rise) start_cnt_r <= start_cnt_r + 2'h1;
          if (startup_done) begin
            state_r <= converter_serial_pkg::ST_RUN;
            frame_sync_pin_o <= cfg.master;
          end
        end
        converter_serial_pkg::ST_RUN: begin
          if (bclk_rise) begin
            pend_r <= fs_seen & ~cfg.sync_align_ctl & ~start;
            frame_sync_pin_o <= 1'b0;
          end
          if (step) begin
            active_r <= 1'b1;
            slot_r <= slot_cur;
            bit_r <= bit_cur + 4'h1;
          end
          if (word_end) begin
            bit_r <= 4'h0;
            slot_r <= slot_cur + 4'h1;
            if (slot_cur == cfg.frame_word_count) begin
              active_r <= 1'b0;
              slot_r <= 4'h0;
              frame_sync_pin_o <= cfg.master;
            end
          end
          if (adv) ptr_r <= xfer ? 2'h0 : ptr_r + 2'h1;
        end
        default: state_r <= converter_serial_pkg::ST_IDLE;
      endcase
    end
  end

  // shift registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txsh_r <= 16'h0;
      rxsh_r <= 16'h0;
      serial_out_pin <= 1'b0;
    end else if (!cfg.enable) begin
      serial_out_pin <= 1'b0;
    end else if (step) begin
      serial_out_pin <= sout_nxt;
      txsh_r <= ((bit_cur == 4'h0) ? tx_word : txsh_r) << 1;
      rxsh_r <= (bit_cur == 4'h0) ? {15'h0, sin} : rxsh_nxt;
    end
  end

  // buffers and holding registers
  generate
    for (genvar i = 0; i < 4; i++) begin : g_loc
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_hold_r[i] <= `HOLD_RESET;
          rx_hold_r[i] <= `HOLD_RESET;
          tx_buf_r[i] <= `HOLD_RESET;
          rx_buf_r[i] <= `HOLD_RESET;
          written_r[i] <= 1'b0;
          unread_r[i] <= 1'b0;
          ovf_r[i] <= 1'b0;
          unf_r[i] <= 1'b0;
        end else begin
          if (tx_wr[i] | (wr & paddr == `OFS_TX_HOLD_0 + 8'(4 * i)))
            tx_hold_r[i] <= pwdata[15:0];
          if (!cfg.enable) rx_buf_r[i] <= `HOLD_RESET;
          else if (adv & rx_on & ptr_r == 2'(i))
            rx_buf_r[i] <= rx_word;
          if (xfer & inuse[i]) begin
            rx_hold_r[i] <= (adv & rx_on & ptr_r == 2'(i)) ? rx_word
              : rx_buf_r[i];
            tx_buf_r[i] <= (written_r[i] | cfg.underflow_fill_mode)
              ? tx_hold_r[i] : 16'h0;
          end
          // set wins over clear on every flag
          if (xfer & inuse[i]) written_r[i] <= 1'b0;
          if (tx_wr[i]) written_r[i] <= 1'b1;
          if (rx_rd[i]) unread_r[i] <= 1'b0;
          if (xfer & ~startup_done & inuse[i]) unread_r[i] <= 1'b1;
          if (rx_rd[i]) ovf_r[i] <= 1'b0;
          if (xfer & inuse[i] & unread_r[i]) ovf_r[i] <= 1'b1;
          if (tx_wr[i]) unf_r[i] <= 1'b0;
          if (xfer & inuse[i] & ~written_r[i]) unf_r[i] <= 1'b1;
        end
      end
    end
  endgenerate

  // status flags and event outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rfull_r <= 1'b0;
      tempty_r <= 1'b0;
      port_irq_flag <= 1'b0;
      buf_irq <= 1'b0;
      err_irq <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      if (|rx_rd & ~|(unread_r & ~rx_rd & inuse)) rfull_r <= 1'b0;
      if (xfer & ~startup_done) rfull_r <= 1'b1;
      if (|tx_wr) tempty_r <= 1'b0;
      if (xfer) tempty_r <= 1'b1;
      port_irq_flag <= rfull_r | tempty_r;
      buf_irq <= xfer;
      err_irq <= err_en_r & xfer
        & |(inuse & (unread_r | ~written_r));
      dma_req <= adv & (cfg.buffer_length == 2'h0);
    end
  end

  assign stat.slot = {1'b0, slot_r};
  assign stat.rx_overflow_flag = |ovf_r;
  assign stat.rx_full_flag = rfull_r;
  assign stat.tx_underflow_flag = |unf_r;
  assign stat.tx_empty_flag = tempty_r;
endmodule : converter_serial_slot_buffer
`default_nettype wire

/* slot_buffer_checker_assertions.sv */
// port assertions for the slot buffer
// assumes control writes arrive over apb as the design decodes them
`default_nettype none
`include "converter_serial_defines.svh"
module slot_buffer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frame_sync_pin_o,
  input wire logic frame_sync_pin_oe,
  input wire logic buf_irq,
  input wire logic err_irq,
  input wire logic dma_req
);
  logic en_r, ms_r, ee_r, wr;
  logic [1:0] bl_r;
  assign wr = psel && penable && pready && pwrite;
  // shadow of the control bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {en_r, ms_r, ee_r, bl_r} <= 5'h00;
    end else if (wr && paddr == `OFS_CTRL_ONE) begin
      {en_r, ms_r} <= {pwdata[`C1_ENABLE], pwdata[`C1_MASTER]};
    end else if (wr && paddr == `OFS_CTRL_TWO) begin
      bl_r <= pwdata[`C2_BUFFER_LENGTH_HI:`C2_BUFFER_LENGTH_LO];
    end else if (wr && paddr == `OFS_ERR_IRQ_EN) begin
      ee_r <= pwdata[0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one)
    else $error("ready held too long");
  property p_refuse;
    psel && !penable && paddr == 8'h18 |=> pslverr && prdata == 32'h0;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("unmapped access not refused");
  property p_txrd;
    psel && !penable && !pwrite && paddr[7:4] == 4'h2 |=> prdata == 32'h0;
  endproperty
  a_txrd: assert property (p_txrd)
    else $error("tx holding read not zero");
  property p_quiet;
    !en_r && !$past(en_r) |-> !(buf_irq || err_irq || dma_req
      || frame_sync_pin_oe || frame_sync_pin_o);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("activity while disabled");
  property p_start;
    $rose(en_r) |-> (!buf_irq)[*8] ##[1:48] buf_irq;
  endproperty
  a_start: assert property (p_start)
    else $error("startup transfer mistimed");
  property p_pulse; buf_irq |=> !buf_irq; endproperty
  a_pulse: assert property (p_pulse)
    else $error("buffer interrupt not a pulse");
  property p_dma; dma_req |-> bl_r == 2'h0; endproperty
  a_dma: assert property (p_dma)
    else $error("dma request with nonzero length");
  property p_err; err_irq |-> ee_r; endproperty
  a_err: assert property (p_err)
    else $error("error interrupt while not enabled");
  property p_oe; frame_sync_pin_oe |-> $past(en_r) && $past(ms_r); endproperty
  a_oe: assert property (p_oe)
    else $error("frame sync driven when not master");
  property p_fs; frame_sync_pin_o |-> frame_sync_pin_oe; endproperty
  a_fs: assert property (p_fs)
    else $error("frame sync high without enable");
  property p_fslen;
    $rose(frame_sync_pin_o) |-> (frame_sync_pin_o || !en_r)[*6]
      ##[1:4] !frame_sync_pin_o;
  endproperty
  a_fslen: assert property (p_fslen)
    else $error("frame sync width wrong");
endmodule : slot_buffer_checker
bind converter_serial_slot_buffer slot_buffer_checker chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .frame_sync_pin_o, .frame_sync_pin_oe, .buf_irq,
  .err_irq, .dma_req
);
`default_nettype wire

/* codec_model.sv */
// codec stand-in: free running bit clock and a steady high data line
// assumes the port samples data on rising bit clock edges
`default_nettype none
module codec_model #(
  parameter int HALF_NS = 80
) (
  output logic bit_clock_pin,
  output logic serial_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // steady high input makes the captured word length visible
  initial begin
    bit_clock_pin = 1'b0;
    serial_in_pin = 1'b1;
    #33;
    forever begin
      #HALF_NS bit_clock_pin = ~bit_clock_pin;
    end
  end
endmodule : codec_model
`default_nettype wire

/* tb_top.sv */
// testbench: apb register checks, loopback, underflow and dma runs
// assumes the codec model supplies the bit clock and serial input
`default_nettype none
`include "converter_serial_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, bit_clock_pin, serial_in_pin, frame_sync_pin_i;
  logic frame_sync_pin_o, frame_sync_pin_oe, serial_out_pin;
  logic port_irq_flag, buf_irq, err_irq, dma_req;
  int n_errors = 0, num_checks = 0, cyc = 0, ecnt = 0, dcnt = 0, mark;
  int hcnt = 0, hmark = 0, t0 = 0;
  localparam logic [15:0] TXW [4] = '{16'ha500, 16'h1100, 16'h3c00, 16'h2200};
  localparam logic [7:0] OFS [7] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h10, 8'h14,
    8'h30};
  converter_serial_slot_buffer dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bit_clock_pin, .serial_in_pin, .frame_sync_pin_i,
    .frame_sync_pin_o, .frame_sync_pin_oe, .serial_out_pin, .port_irq_flag,
    .buf_irq, .err_irq, .dma_req
  );
  codec_model codec (.bit_clock_pin, .serial_in_pin);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (err_irq === 1'b1) ecnt <= ecnt + 1;
    if (dma_req === 1'b1) dcnt <= dcnt + 1;
    if (serial_out_pin === 1'b1) hcnt <= hcnt + 1;
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic check(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdc
  task automatic wait_buf;
    do @(posedge pclk); while (buf_irq !== 1'b1);
  endtask : wait_buf
  task automatic wait_fs;
    do @(posedge pclk); while (frame_sync_pin_o !== 1'b0);
    do @(posedge pclk); while (frame_sync_pin_o !== 1'b1);
  endtask : wait_fs
  // loopback run, four-word buffer, tx slot 0, rx slots 0 and 1
  task automatic run_case(input logic unf);
    wr(`OFS_CTRL_ONE, 32'h0);
    wr(`OFS_TX_SLOT, 32'h1);
    wr(`OFS_RX_SLOT, 32'h3);
    wr(`OFS_ERR_IRQ_EN, 32'h1);
    wr(`OFS_CTRL_TWO, 32'h0c17);
    for (int i = 0; i < 4; i++) wr(8'h20 + 8'(4 * i), {16'h0, TXW[i]});
    mark = ecnt;
    wr(`OFS_CTRL_ONE, {24'h89, unf, 7'h0});
    wait_buf;
    rdc(`OFS_STATUS, 32'hf, 32'h1);
    check({31'h0, port_irq_flag}, 32'h1);
    wait_buf;
    rdc(`OFS_STATUS, 32'h7, 32'h7);
    check({31'h0, ecnt != mark}, 32'h1);
    for (int i = 0; i < 3; i++)
      rdc(8'h30 + 8'(4 * i), 32'hffff, i[0] ? 32'h0 : TXW[i]);
    rdc(`OFS_STATUS, 32'h4, 32'h4);
    wait_buf;
    rdc(`OFS_STATUS, 32'h8, 32'h8);
    rdc(8'h3c, 32'hffff, 32'h0);
    rdc(`OFS_STATUS, 32'h8, 32'h0);
    for (int i = 0; i < 3; i++)
      rdc(8'h30 + 8'(4 * i), 32'hffff,
        unf && !i[0] ? TXW[i] : 32'h0);
    rdc(`OFS_STATUS, 32'h4, 32'h0);
    wr(8'h20, 32'ha500);
    rdc(`OFS_STATUS, 32'h3, 32'h2);
    for (int i = 1; i < 4; i++) wr(8'h20 + 8'(4 * i), 32'h0);
    rdc(`OFS_STATUS, 32'h2, 32'h0);
  endtask : run_case
  task automatic conclude;
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    frame_sync_pin_i = 1'b0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (OFS[i]) rdc(OFS[i], 32'hffffffff, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check({31'h0, se}, 32'h1);
    wr(8'h20, 32'h1234);
    rdc(8'h20, 32'hffffffff, 32'h0);
    wr(`OFS_CTRL_TWO, 32'h0c17);
    rdc(`OFS_CTRL_TWO, 32'hffffffff, 32'h0c17);
    run_case(1'b0);
    run_case(1'b1);
    wr(`OFS_CTRL_ONE, 32'h0);
    wr(`OFS_CTRL_TWO, 32'h0017);
    wr(`OFS_CTRL_ONE, 32'h8120);
    wait_fs;
    mark = dcnt;
    hmark = hcnt;
    wait_fs;
    t0 = cyc;
    wait_fs;
    check(32'(cyc - t0), 32'h80);
    @(posedge pclk);
    check(32'(dcnt - mark), 32'h4);
    check(32'(hcnt - hmark), 32'h20);
    rdc(8'h30, 32'hffff, 32'hff00);
    wr(`OFS_CTRL_ONE, 32'h0);
    conclude();
  end
endmodule : tb_top
`default_nettype wire
